// [port_io_regs.svh]
`ifndef PORT_IO_REGS_SVH
`define PORT_IO_REGS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OFS_PORT_C_PINS 12'h000
`define OFS_PORT_C_OUT_LATCH 12'h004
`define OFS_PORT_C_DIRECTION 12'h008
`define OFS_PORT_D_PINS 12'h00C
`define OFS_PORT_D_OUT_LATCH 12'h010
`define OFS_PORT_D_DIRECTION 12'h014
`define OFS_PORT_E_PINS 12'h018
`define OFS_PORT_E_OUT_LATCH 12'h01C
`define OFS_PORT_E_DIR_AND_SLAVE_CTL 12'h020
`define OFS_ANALOG_CONFIG 12'h024

// ----------------------------------------------------------------
// Port E direction and slave control fields
// ----------------------------------------------------------------
`define BIT_INPUT_FULL 7
`define BIT_OUTPUT_FULL 6
`define BIT_INPUT_OVERFLOW 5
`define BIT_SLAVE_PORT_MODE 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_DIRECTION_8 8'hFF
`define RST_DIRECTION_E 3'h7
`define RST_LATCH_8 8'h00
`define RST_LATCH_E 3'h0
`define RST_ANALOG_SEL 3'h7

`endif

// [port_io_pkg.sv]
package port_io_pkg;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } port8_drive_t;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } port3_drive_t;

  typedef struct packed {
    logic read_n;
    logic write_n;
    logic select_n;
  } slave_strobes_t;

endpackage : port_io_pkg

// [pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Raw pin levels
  output logic [WIDTH-1:0] sync_out // Levels after two flops
);

  logic [WIDTH-1:0] meta_q;

  // Only the second stage is read outside
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pin_sync

`default_nettype wire

// [port_cde_io.sv]
`timescale 1ns/1ps
`default_nettype none
`include "port_io_regs.svh"

module port_cde_io (
  input wire logic pclk, // Core clock, 10 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic por_n, // Low marks power-on reset cause
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [7:0] pin_c_in, // Port C pin levels
  output port_io_pkg::port8_drive_t pin_c_drv, // Port C drive
  input wire logic [7:0] pin_d_in, // Port D pin levels
  output port_io_pkg::port8_drive_t pin_d_drv, // Port D drive
  input wire logic [2:0] pin_e_in, // Port E pin levels
  output port_io_pkg::port3_drive_t pin_e_drv, // Port E drive
  input wire logic [7:0] periph_c_en, // Peripheral owns port C pin
  input wire logic [7:0] periph_c_dir, // Peripheral direction, 1 input
  input wire logic [7:0] periph_c_out, // Peripheral output level
  output logic schmitt_sel // High: Schmitt buffers, low: TTL
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] c_sync;
  logic [7:0] d_sync;
  logic [2:0] e_sync;

  pin_sync #(.WIDTH(8), .RST_VAL(8'h00)) u_sync_c (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_c_in),
    .sync_out(c_sync)
  );

  pin_sync #(.WIDTH(8), .RST_VAL(8'h00)) u_sync_d (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_d_in),
    .sync_out(d_sync)
  );

  // Strobes idle high, so they rest inactive through reset
  pin_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync_e (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_e_in),
    .sync_out(e_sync)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] lat_c_q;
  logic [7:0] dir_c_q;
  logic [7:0] lat_d_q;
  logic [7:0] dir_d_q;
  logic [2:0] lat_e_q;
  logic [2:0] dir_e_q;
  logic [2:0] analog_sel_q;
  logic slave_mode_q;
  logic in_full_q;
  logic out_full_q;
  logic in_ovf_q;
  logic [7:0] slave_in_q;
  logic rd_seen_q;
  logic wr_seen_q;
  logic por_seen_q;

  port_io_pkg::slave_strobes_t strb;
  logic ext_rd_act;
  logic ext_wr_act;
  logic ext_rd_start;
  logic ext_wr_start;
  logic wr_en;
  logic rd_en;
  logic cpu_rd_d;
  logic cpu_wr_d;
  logic ctl_wr;

  // Once per transfer: a second edge would clear a flag set meanwhile
  assign wr_en = psel && penable && pwrite && !pready;
  assign rd_en = psel && penable && !pwrite && !pready;
  // Reading port D in slave mode hands over the received word
  assign cpu_rd_d = rd_en && (paddr == `OFS_PORT_D_PINS);
  assign cpu_wr_d = wr_en && (paddr == `OFS_PORT_D_PINS || paddr == `OFS_PORT_D_OUT_LATCH);
  assign ctl_wr = wr_en && (paddr == `OFS_PORT_E_DIR_AND_SLAVE_CTL);

  // ----------------------------------------------------------------
  // Slave port strobe decode
  // ----------------------------------------------------------------
  // Strobes count only with select low and slave mode on
  assign strb = '{read_n: e_sync[0], write_n: e_sync[1], select_n: e_sync[2]};
  assign ext_rd_act = slave_mode_q && !strb.select_n && !strb.read_n;
  assign ext_wr_act = slave_mode_q && !strb.select_n && !strb.write_n;
  assign ext_rd_start = ext_rd_act && !rd_seen_q;
  assign ext_wr_start = ext_wr_act && !wr_seen_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_seen_q <= 1'b0;
      wr_seen_q <= 1'b0;
    end
    else
    begin
      rd_seen_q <= ext_rd_act;
      wr_seen_q <= ext_wr_act;
    end
  end

  // Data is taken when the strobe is first seen low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slave_in_q <= 8'h00;
    else if (ext_wr_start)
      slave_in_q <= d_sync;
  end

  // ----------------------------------------------------------------
  // Status flags: the set condition wins over the clear
  // ----------------------------------------------------------------
  // A new word outranks a CPU read in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_full_q <= 1'b0;
    else if (ext_wr_start)
      in_full_q <= 1'b1;
    else if (cpu_rd_d)
      in_full_q <= 1'b0;
  end

  // Only a slave-mode write waits for the external reader
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_full_q <= 1'b0;
    else if (cpu_wr_d && slave_mode_q)
      out_full_q <= 1'b1;
    else if (ext_rd_start)
      out_full_q <= 1'b0;
  end

  // Cleared only by a written zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_ovf_q <= 1'b0;
    else if (ext_wr_start && in_full_q && !cpu_rd_d)
      in_ovf_q <= 1'b1;
    else if (ctl_wr && !pwdata[`BIT_INPUT_OVERFLOW])
      in_ovf_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------
  // Peripheral overrides act only on the drivers, never here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lat_c_q <= `RST_LATCH_8;
      dir_c_q <= `RST_DIRECTION_8;
      lat_d_q <= `RST_LATCH_8;
      dir_d_q <= `RST_DIRECTION_8;
      lat_e_q <= `RST_LATCH_E;
      dir_e_q <= `RST_DIRECTION_E;
      slave_mode_q <= 1'b0;
    end
    else if (wr_en)
    begin
      case (paddr)
        `OFS_PORT_C_PINS, `OFS_PORT_C_OUT_LATCH: lat_c_q <= pwdata[7:0];
        `OFS_PORT_C_DIRECTION: dir_c_q <= pwdata[7:0];
        `OFS_PORT_D_PINS, `OFS_PORT_D_OUT_LATCH: lat_d_q <= pwdata[7:0];
        `OFS_PORT_D_DIRECTION: dir_d_q <= pwdata[7:0];
        `OFS_PORT_E_PINS, `OFS_PORT_E_OUT_LATCH: lat_e_q <= pwdata[2:0];
        `OFS_PORT_E_DIR_AND_SLAVE_CTL:
        begin
          dir_e_q <= pwdata[2:0];
          slave_mode_q <= pwdata[`BIT_SLAVE_PORT_MODE];
        end
        default: ;
      endcase
    end
  end

  // Analog selection: all analog on every reset, reloaded in the first cycle after a power-on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      por_seen_q <= 1'b0;
    else
      por_seen_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      analog_sel_q <= `RST_ANALOG_SEL;
    else if (!por_seen_q && !por_n)
      analog_sel_q <= `RST_ANALOG_SEL;
    else if (wr_en && paddr == `OFS_ANALOG_CONFIG)
      analog_sel_q <= pwdata[2:0];
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic [7:0] c_oe_d;
  logic [7:0] c_out_d;

  // Override chosen per pin; the direction register never sees it
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_c_pin
      assign c_oe_d[gi] = periph_c_en[gi] ? !periph_c_dir[gi] : !dir_c_q[gi];
      assign c_out_d[gi] = periph_c_en[gi] ? periph_c_out[gi] : lat_c_q[gi];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_c_drv <= '{out: 8'h00, oe: 8'h00};
    else
      pin_c_drv <= '{out: c_out_d, oe: c_oe_d};
  end

  // In slave mode the bus is driven only while an external read is active
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_d_drv <= '{out: 8'h00, oe: 8'h00};
    else if (slave_mode_q)
      pin_d_drv <= '{out: lat_d_q, oe: {8{ext_rd_act}}};
    else
      pin_d_drv <= '{out: lat_d_q, oe: ~dir_d_q};
  end

  // Analog pins stay driven per direction: software must keep them inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_e_drv <= '{out: 3'h0, oe: 3'h0};
    else
      pin_e_drv <= '{out: lat_e_q, oe: ~dir_e_q};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      schmitt_sel <= 1'b1;
    else
      schmitt_sel <= !slave_mode_q;
  end

  // ----------------------------------------------------------------
  // APB read and response
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `OFS_PORT_C_PINS) || (a == `OFS_PORT_C_OUT_LATCH)
      || (a == `OFS_PORT_C_DIRECTION) || (a == `OFS_PORT_D_PINS)
      || (a == `OFS_PORT_D_OUT_LATCH) || (a == `OFS_PORT_D_DIRECTION)
      || (a == `OFS_PORT_E_PINS) || (a == `OFS_PORT_E_OUT_LATCH)
      || (a == `OFS_PORT_E_DIR_AND_SLAVE_CTL) || (a == `OFS_ANALOG_CONFIG);
  endfunction : is_mapped

  // Decoded from the address held through the access phase
  logic [31:0] rdata_d;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `OFS_PORT_C_PINS: rdata_d[7:0] = c_sync;
      `OFS_PORT_C_OUT_LATCH: rdata_d[7:0] = lat_c_q;
      `OFS_PORT_C_DIRECTION: rdata_d[7:0] = dir_c_q;
      `OFS_PORT_D_PINS: rdata_d[7:0] = slave_mode_q ? slave_in_q : d_sync;
      `OFS_PORT_D_OUT_LATCH: rdata_d[7:0] = lat_d_q;
      `OFS_PORT_D_DIRECTION: rdata_d[7:0] = dir_d_q;
      `OFS_PORT_E_PINS: rdata_d[2:0] = e_sync & ~analog_sel_q;
      `OFS_PORT_E_OUT_LATCH: rdata_d[2:0] = lat_e_q;
      `OFS_PORT_E_DIR_AND_SLAVE_CTL:
        rdata_d[7:0] = {in_full_q, out_full_q, in_ovf_q, slave_mode_q, 1'b0, dir_e_q};
      `OFS_ANALOG_CONFIG: rdata_d[2:0] = analog_sel_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // One wait state: answer comes on the second access-phase edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !is_mapped(paddr);
      prdata <= (psel && penable && !pwrite && !pready) ? rdata_d : 32'h0000_0000;
    end
  end

endmodule : port_cde_io

`default_nettype wire

// [port_cde_io_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module port_cde_io_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic [2:0] pin_e_in, // Strobe pins
  input wire port_io_pkg::port8_drive_t pin_c_drv, // C drive
  input wire port_io_pkg::port8_drive_t pin_d_drv, // D drive
  input wire logic [7:0] periph_c_en, // Override on
  input wire logic [7:0] periph_c_dir, // Override dir
  input wire logic [7:0] periph_c_out, // Override level
  input wire logic schmitt_sel // Buffer kind
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence ctl_wr;
    psel && penable && !pready && pwrite && paddr == 12'h020;
  endsequence
  sequence rd_start;
    !schmitt_sel && $fell(pin_e_in[0]) && !pin_e_in[2];
  endsequence
  e_pins_zero_a: assert property (
    pready && paddr inside {12'h018, 12'h01C} |-> prdata[31:3] == '0) else $error("e upper bits");
  ctl_bits_a: assert property (
    pready && paddr == 12'h020 |-> prdata[31:8] == '0 && !prdata[3]) else $error("ctl bit3");
  cd_width_a: assert property (
    pready && paddr <= 12'h014 |-> prdata[31:8] == '0) else $error("c d width");
  periph_ovr_a: assert property ($past(presetn) |->
    ((pin_c_drv.oe ^ ~$past(periph_c_dir)) & $past(periph_c_en)) == '0
    && ((pin_c_drv.out ^ $past(periph_c_out)) & $past(periph_c_en & ~periph_c_dir)) == '0)
    else $error("override");
  slave_rd_a: assert property (rd_start |-> ##[1:5] pin_d_drv.oe == 8'hFF)
    else $error("slave read drive");
  desel_quiet_a: assert property ((!schmitt_sel && pin_e_in[2]) [*6] |-> pin_d_drv.oe == '0)
    else $error("deselected drive");
  mode_buf_a: assert property (ctl_wr |-> ##2 schmitt_sel == !$past(pwdata[4], 2))
    else $error("buffer kind");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("wait state");
endmodule : port_cde_io_chk
bind port_cde_io port_cde_io_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pin_e_in(pin_e_in), .pin_c_drv(pin_c_drv), .pin_d_drv(pin_d_drv),
  .periph_c_en(periph_c_en), .periph_c_dir(periph_c_dir), .periph_c_out(periph_c_out),
  .schmitt_sel(schmitt_sel));
`default_nettype wire

// [slave_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module slave_host_model (
  input wire logic pclk, // Core clock
  input wire logic [7:0] d_bus, // Port D wire level
  output port_io_pkg::slave_strobes_t strb, // Strobes
  output logic [7:0] d_out // Level put on the data bus
);
  initial strb = 3'b111;
  initial d_out = 8'h00;
  // ----
  // One access; hold sets prompt or slow
  // ----
  task automatic xfer(input logic wr, input logic sel, input logic [7:0] d, input int hold,
                      output logic [7:0] q);
    @(posedge pclk);
    strb.select_n <= !sel;
    strb.write_n <= !wr;
    strb.read_n <= wr;
    d_out <= d;
    repeat (hold) @(posedge pclk);
    q = d_bus;
    strb <= 3'b111;
    d_out <= ~d; // Released bus must not keep the last value
    repeat (4) @(posedge pclk);
  endtask : xfer
endmodule : slave_host_model
`default_nettype wire

// [port_cde_io_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module port_cde_io_tb_top;
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic schmitt_sel, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0] c_ext = 8'h00, periph_c_en = '0, periph_c_dir = '0, periph_c_out = '0;
  logic [7:0] d_host, hq;
  port_io_pkg::port8_drive_t pin_c_drv, pin_d_drv;
  port_io_pkg::port3_drive_t pin_e_drv;
  port_io_pkg::slave_strobes_t strb;
  int mismatches = 0, checks_done = 0;
  wire logic [7:0] pin_c_in = (pin_c_drv.oe & pin_c_drv.out) | (~pin_c_drv.oe & c_ext);
  wire logic [7:0] pin_d_in = (pin_d_drv.oe & pin_d_drv.out) | (~pin_d_drv.oe & d_host);
  wire logic [2:0] pin_e_in = (pin_e_drv.oe & pin_e_drv.out)
                              | (~pin_e_drv.oe & {strb.select_n, strb.write_n, strb.read_n});
  always #50 pclk = ~pclk;
  port_cde_io uut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_c_in(pin_c_in), .pin_c_drv(pin_c_drv),
    .pin_d_in(pin_d_in), .pin_d_drv(pin_d_drv), .pin_e_in(pin_e_in), .pin_e_drv(pin_e_drv),
    .periph_c_en(periph_c_en), .periph_c_dir(periph_c_dir), .periph_c_out(periph_c_out),
    .schmitt_sel(schmitt_sel));
  slave_host_model host (.pclk(pclk), .d_bus(pin_d_in), .strb(strb), .d_out(d_host));
  // ----
  // Bus tasks
  // ----
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(a, 0, 0);
    chk($sformatf("reg %h", a), rd, e);
  endtask : rchk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    por_n <= 1;
    rchk(12'h008, 32'hFF);
    rchk(12'h014, 32'hFF);
    rchk(12'h020, 32'h07);
    rchk(12'h024, 32'h07);
    rchk(12'h018, 32'h00);
    apb(12'h030, 1, 32'hFF);
    chk("unmapped err", err, 1'b1);
    $display("test reset done");
    c_ext <= 8'hA5;
    apb(12'h000, 1, 32'h5A);
    apb(12'h008, 1, 32'h0F);
    rchk(12'h004, 32'h5A);
    rchk(12'h000, 32'h55);
    chk("c oe", pin_c_drv.oe, 8'hF0);
    chk("c out", pin_c_drv.out[7:4], 4'h5);
    periph_c_en <= 8'h81;
    periph_c_dir <= 8'h80;
    periph_c_out <= 8'h01;
    repeat (2) @(posedge pclk);
    chk("c oe ovr", pin_c_drv.oe, 8'h71);
    rchk(12'h008, 32'h0F);
    periph_c_en <= 8'h00;
    $display("test port c done");
    apb(12'h024, 1, 32'h00);
    apb(12'h01C, 1, 32'h05);
    apb(12'h020, 1, 32'h00);
    apb(12'h010, 1, 32'hC3);
    apb(12'h014, 1, 32'h00);
    repeat (4) @(posedge pclk);
    rchk(12'h018, 32'h05);
    chk("e oe", pin_e_drv.oe, 3'h7);
    rchk(12'h00C, 32'hC3);
    apb(12'h014, 1, 32'hFF);
    apb(12'h020, 1, 32'hDF);
    rchk(12'h020, 32'h17);
    chk("buffer", schmitt_sel, 1'b0);
    $display("test port d e done");
    host.xfer(1, 1, 8'h3C, 6, hq);
    rchk(12'h020, 32'h97);
    rchk(12'h00C, 32'h3C);
    rchk(12'h020, 32'h17);
    host.xfer(1, 1, 8'h11, 6, hq);
    host.xfer(1, 1, 8'h22, 3, hq);
    rchk(12'h020, 32'hB7);
    apb(12'h020, 1, 32'h17);
    rchk(12'h020, 32'h97);
    apb(12'h00C, 0, 0);
    host.xfer(1, 0, 8'h55, 6, hq);
    rchk(12'h020, 32'h17);
    apb(12'h00C, 1, 32'h96);
    rchk(12'h020, 32'h57);
    host.xfer(0, 0, 8'h00, 6, hq);
    rchk(12'h020, 32'h57);
    host.xfer(0, 1, 8'h00, 6, hq);
    chk("ext read", hq, 8'h96);
    rchk(12'h020, 32'h17);
    apb(12'h020, 1, 32'h07);
    @(posedge pclk);
    chk("buffer", schmitt_sel, 1'b1);
    $display("test slave port done");
    tally_and_finish();
  end
endmodule : port_cde_io_tb_top
`default_nettype wire
